// >>> verilog/fcs_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps

// What this block does
// RULE1 - Writing one to buffer-empty launches the command; flag clears until handed over.
// RULE2 - Only burst program commands may be queued, and only behind a running burst program.
// RULE3 - Complete flag sets whenever buffer is empty and nothing is running.
// RULE4 - Complete flag clears on launch; software writes to it do nothing.
// RULE5 - Launch touching a protected location sets protection flag and drops command.
// RULE6 - Protection flag clears only by software writing one.
// RULE7 - Broken write sequence sets access error and drops the command.
// RULE8 - Program or erase before divider setup sets access error.
// RULE9 - Entering stop while a command runs sets access error.
// RULE10 - Access error clears on write of one; zero leaves it.
// RULE11 - Blank check sets erased flag when whole array reads all ones.
// RULE12 - Erased flag clears on valid launch; software writes do nothing.
// RULE13 - Codes 05, 20, 25 mean blank check, byte and burst program.
// RULE14 - Codes 40, 41 mean page erase of 512 bytes and mass erase.
// RULE15 - Any other code is illegal and sets access error.
// RULE16 - Software needs blank check only to unlock security, not after erase.
// RULE17 - Status bits 3, 1, 0 read zero and ignore writes.
// RULE18 - Passing blank check sets security state to unsecured.
// RULE19 - Software writes array, then command, then launches, polling complete flag.
// RULE20 - Reset leaves empty and complete set, errors clear; command reads zero.
module fcs_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Software access to the array and system state
    input  wire logic        arr_write,
    input  wire logic        arr_addr_protected,
    input  wire logic        protect_any,
    input  wire logic        divider_ready,
    input  wire logic        stop_entry,
    input  wire logic [1:0]  sec_nv,
    // Array engine
    input  wire logic        arr_done,
    input  wire logic        arr_blank_ok,
    output logic             arr_start,
    output logic      [6:0]  arr_cmd,
    output logic      [1:0]  security_state
);

    fcs_pkg::fcs_seq_e seq_q;
    fcs_pkg::fcs_seq_e seq_d;
    logic [6:0] code_q;
    logic       prot_q;
    logic       cbef_q;
    logic       ccf_q;
    logic       pviol_q;
    logic       acc_q;
    logic       blank_q;
    logic [1:0] sec_q;
    logic       sec_loaded_q;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;

    // Bus decode; a transfer completes on the access edge with pready high.
    wire        sel_stat   = (paddr == {fcs_pkg::FCS_STAT_IDX[13:0], 2'b00});
    wire        sel_cmd    = (paddr == {fcs_pkg::FCS_CMD_IDX[13:0], 2'b00});
    wire        setup      = psel && !penable;
    wire        wr_done    = psel && penable && pwrite && pready_q;
    wire        wr_stat    = wr_done && sel_stat;
    wire        wr_cmd     = wr_done && sel_cmd;
    wire        wr_launch  = wr_stat && pwdata[fcs_pkg::FCS_CBEF_BIT];
    wire        clr_pviol  = wr_stat && pwdata[fcs_pkg::FCS_PVIOL_BIT];
    wire        clr_acc    = wr_stat && pwdata[fcs_pkg::FCS_ACC_BIT];
    wire [7:0]  stat_word  = {cbef_q, ccf_q, pviol_q, acc_q, 1'b0, blank_q, 2'b00};

    // Command decode.
    // RULE13 RULE14 command codes
    wire        is_blank   = (code_q == fcs_pkg::FCS_CMD_BLANK);
    wire        is_byte    = (code_q == fcs_pkg::FCS_CMD_BYTE);
    wire        is_burst   = (code_q == fcs_pkg::FCS_CMD_BURST);
    wire        is_page    = (code_q == fcs_pkg::FCS_CMD_PAGE);
    wire        is_mass    = (code_q == fcs_pkg::FCS_CMD_MASS);
    wire        is_legal   = is_blank || is_byte || is_burst || is_page || is_mass;
    wire        is_modify  = is_byte || is_burst || is_page || is_mass;

    // Engine hand-off signals.
    logic       take;
    logic       busy;
    logic       run_burst;
    logic       blank_pass;

    // Sequence checks on array writes, command writes and launch.
    wire        launch     = wr_launch && (seq_q == fcs_pkg::SEQ_LOADED);
    wire        seq_err    = (arr_write && (seq_q != fcs_pkg::SEQ_IDLE || !cbef_q))
                          || (wr_cmd && seq_q != fcs_pkg::SEQ_ARMED)
                          || (wr_launch && seq_q != fcs_pkg::SEQ_LOADED);
    wire        div_err    = launch && is_modify && !divider_ready;
    // Only a burst may wait behind a running burst; any other launch would clobber the buffer.
    wire        queue_err  = launch && busy && !(is_burst && run_burst);
    wire        illegal    = launch && !is_legal;
    // Protection is reported only for a launch free of illegal code, divider and queue errors, so none of those raises both flags.
    wire        prot_hit   = launch && is_legal && is_modify && divider_ready && !queue_err
                          && (is_mass ? protect_any : prot_q);
    wire        acc_set    = seq_err || div_err || queue_err || illegal || (stop_entry && busy);
    wire        launch_ok  = launch && !acc_set && !prot_hit;

    // Write sequence tracking: array write, then code, then launch.
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            fcs_pkg::SEQ_IDLE: begin
                if (arr_write && cbef_q && !wr_cmd && !wr_launch) begin
                    seq_d = fcs_pkg::SEQ_ARMED;
                end
            end
            fcs_pkg::SEQ_ARMED: begin
                if (wr_cmd && !arr_write) begin
                    seq_d = fcs_pkg::SEQ_LOADED;
                end else if (arr_write || wr_launch) begin
                    seq_d = fcs_pkg::SEQ_IDLE;
                end
            end
            fcs_pkg::SEQ_LOADED: begin
                if (wr_launch || wr_cmd || arr_write) begin
                    seq_d = fcs_pkg::SEQ_IDLE;
                end
            end
        endcase
    end

    // Sequence state, captured code and protection sample of the target.
    // RULE7 sequence and code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q  <= fcs_pkg::SEQ_IDLE;
            code_q <= fcs_pkg::FCS_CMD_RESET;
            prot_q <= 1'b0;
        end else begin
            seq_q  <= seq_d;
            code_q <= wr_cmd ? pwdata[6:0] : code_q;
            prot_q <= arr_write ? arr_addr_protected : prot_q;
        end
    end

    // Buffer empty flag: cleared by an accepted launch, set when handed over.
    // RULE1 RULE2 launch and buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbef_q <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_CBEF_BIT];
        end else if (launch_ok) begin
            cbef_q <= 1'b0;
        end else if (take) begin
            cbef_q <= 1'b1;
        end
    end

    // Complete flag tracks an empty buffer with an idle engine.
    // RULE3 RULE4 complete flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccf_q <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_CCF_BIT];
        end else if (launch_ok) begin
            ccf_q <= 1'b0;
        end else if (cbef_q && !busy) begin
            ccf_q <= 1'b1;
        end
    end

    // Error flags are sticky; a new event wins over a clear in the same cycle.
    // RULE5 RULE6 RULE8 RULE9 RULE10 RULE15 error flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pviol_q <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_PVIOL_BIT];
            acc_q   <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_ACC_BIT];
        end else begin
            pviol_q <= prot_hit || (pviol_q && !clr_pviol);
            acc_q   <= acc_set || (acc_q && !clr_acc);
        end
    end

    // Erased flag: set by a passing blank check, cleared by the next valid launch.
    // RULE11 RULE12 erased flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_q <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_BLANK_BIT];
        end else if (blank_pass) begin
            blank_q <= 1'b1;
        end else if (launch_ok) begin
            blank_q <= 1'b0;
        end
    end

    // Security state is taken from the stored value just after reset release,
    // because an asynchronous reset may only load a constant.
    // RULE18 security unlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q        <= fcs_pkg::FCS_SEC_RESET;
            sec_loaded_q <= 1'b0;
        end else begin
            sec_loaded_q <= 1'b1;
            if (blank_pass) begin
                sec_q <= fcs_pkg::FCS_SEC_UNSECURED;
            end else if (!sec_loaded_q) begin
                sec_q <= sec_nv;
            end
        end
    end

    // APB answer is prepared in the setup cycle, so there are no wait states.
    // RULE17 RULE20 read values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !sel_stat && !sel_cmd;
            prdata_q  <= (setup && sel_stat) ? {24'h00_0000, stat_word} : 32'h0000_0000;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign security_state = sec_q;

    // Array engine; its start and code outputs are flip-flops.
    // RULE13 RULE14 command hand-off
    fcs_array_seq u_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .buf_valid    (!cbef_q),
        .buf_code     (code_q),
        .take         (take),
        .busy         (busy),
        .run_burst    (run_burst),
        .blank_pass_q (blank_pass),
        .arr_done     (arr_done),
        .arr_blank_ok (arr_blank_ok),
        .arr_start_q  (arr_start),
        .arr_cmd_q    (arr_cmd)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hand;
        take ##1 arr_start;
    endsequence

    a_launch_clears_empty: assert property (launch_ok |=> !cbef_q) // RULE1
        else $error("Buffer empty flag did not clear after launch.");
    a_launch_hand_off: assert property (launch_ok && !busy |=> s_hand) // RULE2
        else $error("Launched command was not handed to the array.");
    a_complete_when_idle: assert property (cbef_q && !busy && !launch_ok |=> ccf_q) // RULE3
        else $error("Complete flag not set with empty buffer and idle engine.");
    a_complete_clear_launch: assert property ( // RULE4
        launch_ok |=> !ccf_q && blank_q == $past(blank_pass))
        else $error("Complete or erased flag survived a launch.");
    a_protect_discard: assert property (prot_hit |=> pviol_q && cbef_q && !arr_start) // RULE5
        else $error("Protected command was not discarded with violation flag.");
    a_protect_sticky: assert property (pviol_q && !clr_pviol |=> pviol_q) // RULE6
        else $error("Protection flag cleared without a write of one.");
    a_illegal_access_err: assert property (illegal |=> acc_q && cbef_q) // RULE15
        else $error("Illegal code did not raise access error.");
    a_divider_access_err: assert property (div_err |=> acc_q) // RULE8
        else $error("Missing divider setup did not raise access error.");
    a_stop_access_err: assert property (stop_entry && busy |=> acc_q) // RULE9
        else $error("Stop during a command did not raise access error.");
    a_access_zero_write: assert property (acc_q && wr_stat && !clr_acc |=> acc_q) // RULE10
        else $error("Writing zero cleared the access error flag.");
    a_blank_unlock: assert property (blank_pass |=> blank_q && sec_q == 2'h2) // RULE18
        else $error("Passing blank check did not set erased flag and unlock.");
    a_reserved_read_zero: assert property (pready_q |-> (prdata_q[3:0] & 4'hB) == 4'h0) // RULE17
        else $error("Reserved status bits read nonzero.");

    // Flags move only as software or the array asks; refused launches buffer nothing.
    sequence s_refill;
        cbef_q && arr_start;
    endsequence

    a_burst_refill: assert property (take |=> s_refill) // RULE1
        else $error("Handed command did not empty the buffer and start the array.");
    a_queue_refused: assert property (queue_err |=> acc_q && cbef_q) // RULE2
        else $error("Refused queued command was buffered.");
    a_complete_set_idle: assert property ($rose(ccf_q) |-> $past(cbef_q && !busy)) // RULE3
        else $error("Complete flag set while a command was pending.");
    a_protect_clear_one: assert property (pviol_q && clr_pviol && !prot_hit |=> !pviol_q) // RULE6
        else $error("Writing one did not clear the protection flag.");
    a_seq_error_flag: assert property (seq_err |=> acc_q) // RULE7
        else $error("Broken write sequence did not raise access error.");
    a_access_clear_one: assert property (acc_q && clr_acc && !acc_set |=> !acc_q) // RULE10
        else $error("Writing one did not clear the access error flag.");
    a_erased_write_ignored: assert property ( // RULE12
        wr_stat && !launch_ok && !blank_pass |=> blank_q == $past(blank_q))
        else $error("Software write changed the erased flag.");
    a_code_handed: assert property (arr_start |-> arr_cmd == $past(code_q)) // RULE13
        else $error("Handed code differs from the buffered code.");

endmodule : fcs_ctrl

// >>> verilog/fcs_pkg.sv
package fcs_pkg;

    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [15:0] FCS_STAT_IDX = 16'h1825;
    localparam logic [15:0] FCS_CMD_IDX  = 16'h1826;

    // Status register field positions.
    localparam int FCS_CBEF_BIT  = 7;
    localparam int FCS_CCF_BIT   = 6;
    localparam int FCS_PVIOL_BIT = 5;
    localparam int FCS_ACC_BIT   = 4;
    localparam int FCS_BLANK_BIT = 2;

    // Reset values.
    localparam logic [7:0] FCS_STAT_RESET = 8'hC0;
    localparam logic [6:0] FCS_CMD_RESET  = 7'h00;
    localparam logic [1:0] FCS_SEC_RESET  = 2'h3;

    // Command codes.
    localparam logic [6:0] FCS_CMD_BLANK = 7'h05;
    localparam logic [6:0] FCS_CMD_BYTE  = 7'h20;
    localparam logic [6:0] FCS_CMD_BURST = 7'h25;
    localparam logic [6:0] FCS_CMD_PAGE  = 7'h40;
    localparam logic [6:0] FCS_CMD_MASS  = 7'h41;

    // Security state encoding reached after a passing blank check.
    localparam logic [1:0] FCS_SEC_UNSECURED = 2'h2;

    // Page size in bytes for the page erase command.
    localparam int FCS_PAGE_BYTES = 512;

    // Software write sequence states.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ARMED,
        SEQ_LOADED
    } fcs_seq_e;

    // Array engine states.
    typedef enum logic {
        ENG_IDLE,
        ENG_RUN
    } fcs_eng_e;

endpackage : fcs_pkg

// >>> verilog/fcs_array_seq.sv
`timescale 1ns/100ps

// Hands one buffered command at a time to the array and waits for it.
module fcs_array_seq (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Command buffer side
    input  wire logic       buf_valid,
    input  wire logic [6:0] buf_code,
    output logic            take,
    output logic            busy,
    output logic            run_burst,
    output logic            blank_pass_q,
    // Array side
    input  wire logic       arr_done,
    input  wire logic       arr_blank_ok,
    output logic            arr_start_q,
    output logic [6:0]      arr_cmd_q
);

    fcs_pkg::fcs_eng_e state_q;
    fcs_pkg::fcs_eng_e state_d;
    logic              fin;

    // The buffer is only drained while the array is idle.
    assign take      = buf_valid && (state_q == fcs_pkg::ENG_IDLE);
    assign busy      = (state_q == fcs_pkg::ENG_RUN);
    assign fin       = busy && arr_done;
    assign run_burst = busy && (arr_cmd_q == fcs_pkg::FCS_CMD_BURST);

    // Engine state follows the take and the array completion.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fcs_pkg::ENG_IDLE: begin
                if (take) begin
                    state_d = fcs_pkg::ENG_RUN;
                end
            end
            fcs_pkg::ENG_RUN: begin
                if (arr_done) begin
                    state_d = fcs_pkg::ENG_IDLE;
                end
            end
        endcase
    end

    // Start pulse, latched code and blank result are all registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= fcs_pkg::ENG_IDLE;
            arr_start_q  <= 1'b0;
            arr_cmd_q    <= fcs_pkg::FCS_CMD_RESET;
            blank_pass_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            arr_start_q  <= take;
            arr_cmd_q    <= take ? buf_code : arr_cmd_q;
            blank_pass_q <= fin && arr_blank_ok && (arr_cmd_q == fcs_pkg::FCS_CMD_BLANK);
        end
    end

endmodule : fcs_array_seq

// >>> bench/fcs_ctrl_test.sv
`timescale 1ns/100ps

// Drives the block over its register bus and array pins and checks status words.
module fcs_ctrl_test;

    localparam logic [15:0] STAT = fcs_pkg::FCS_STAT_IDX * 16'h0004;
    localparam logic [15:0] CMD  = fcs_pkg::FCS_CMD_IDX * 16'h0004;

    logic        pclk;
    logic        presetn;
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        arr_write;
    logic        arr_addr_protected;
    logic        protect_any;
    logic        divider_ready;
    logic        stop_entry;
    logic [1:0]  sec_nv;
    logic        arr_done;
    logic        arr_blank_ok;
    logic        arr_start;
    logic [6:0]  arr_cmd;
    logic [1:0]  security_state;
    int          bad_count;
    int          check_count;
    int          start_cnt;
    int          cyc;
    logic [6:0]  last_cmd;
    logic [31:0] d;
    logic        e;
    logic [6:0]  codes [5];

    fcs_ctrl DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arr_write(arr_write), .arr_addr_protected(arr_addr_protected),
        .protect_any(protect_any), .divider_ready(divider_ready), .stop_entry(stop_entry),
        .sec_nv(sec_nv), .arr_done(arr_done), .arr_blank_ok(arr_blank_ok),
        .arr_start(arr_start), .arr_cmd(arr_cmd), .security_state(security_state)
    );

    // Clock generator, 40 ns period.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Hand-offs are counted at the falling edge, where the pulse is settled.
    always @(negedge pclk) begin
        if (arr_start === 1'b1) begin
            start_cnt++;
            last_cmd = arr_cmd;
        end
    end

    // A hung handshake must not stall the run forever.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            $display("ERROR %0t: run timed out", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus transfer; the request holds until the rising edge where pready is seen high.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Data and error are taken at the very edge that shows pready high; a hang ends by timeout.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_stat(input logic [7:0] exp);
        apb(1'b0, STAT, 32'h0000_0000);
        chk(d[7:0], exp);
    endtask : rd_stat

    // Array write, command write, then launch by writing one to the empty flag.
    // software write order
    task automatic launch(input logic [6:0] code, input logic prot);
        @(posedge pclk);
        arr_write          <= 1'b1;
        arr_addr_protected <= prot;
        @(posedge pclk);
        arr_write          <= 1'b0;
        arr_addr_protected <= 1'b0;
        apb(1'b1, CMD, {25'h0000000, code});
        apb(1'b1, STAT, 32'h0000_0080);
    endtask : launch

    task automatic finish_cmd(input logic ok);
        @(posedge pclk);
        arr_done     <= 1'b1;
        arr_blank_ok <= ok;
        @(posedge pclk);
        arr_done     <= 1'b0;
        arr_blank_ok <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : finish_cmd

    initial begin
        {presetn, psel, penable, pwrite, arr_write, arr_addr_protected} = 6'h00;
        {protect_any, stop_entry, arr_done, arr_blank_ok} = 4'h0;
        divider_ready = 1'b1;
        sec_nv        = 2'h1;
        paddr         = 16'h0000;
        pwdata        = 32'h0000_0000;
        {bad_count, check_count, start_cnt, cyc} = '0;
        codes = '{7'h20, 7'h25, 7'h40, 7'h41, 7'h05};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_stat(8'hC0);
        apb(1'b0, CMD, 32'h0000_0000);
        chk(d[7:0], 8'h00);
        chk({6'h00, security_state}, {6'h00, sec_nv});
        // Unmapped place answers with an error and zero data.
        apb(1'b0, 16'h6090, 32'h0000_0000);
        chk({7'h00, e}, 8'h01);
        chk(d[7:0], 8'h00);
        // blank check passes; the hand-off shows two edges after the launch.
        launch(fcs_pkg::FCS_CMD_BLANK, 1'b0);
        rd_stat(8'h80);
        chk(8'(start_cnt), 8'h01);
        finish_cmd(1'b1);
        rd_stat(8'hC4);
        chk({6'h00, security_state}, {6'h00, fcs_pkg::FCS_SEC_UNSECURED});
        apb(1'b1, STAT, 32'h0000_004F);
        rd_stat(8'hC4);
        // every code, erase codes, blank cleared.
        // the blank check after the mass erase is optional here.
        foreach (codes[i]) begin
            launch(codes[i], 1'b0);
            rd_stat(8'h80);
            chk({1'b0, last_cmd}, {1'b0, codes[i]});
            chk(8'(start_cnt), 8'(i + 2));
            finish_cmd(1'b0);
            rd_stat(8'hC0);
        end
        // a second burst is queued behind a running one.
        launch(fcs_pkg::FCS_CMD_BURST, 1'b0);
        launch(fcs_pkg::FCS_CMD_BURST, 1'b0);
        rd_stat(8'h00);
        finish_cmd(1'b0);
        chk(8'(start_cnt), 8'h08);
        rd_stat(8'h80);
        finish_cmd(1'b0);
        // illegal code, clear by one only.
        launch(7'h33, 1'b0);
        rd_stat(8'hD0);
        apb(1'b1, STAT, 32'h0000_0000);
        rd_stat(8'hD0);
        apb(1'b1, STAT, 32'h0000_0010);
        rd_stat(8'hC0);
        // command write without the array write.
        apb(1'b1, CMD, 32'h0000_0020);
        rd_stat(8'hD0);
        apb(1'b1, STAT, 32'h0000_0010);
        divider_ready <= 1'b0;
        launch(fcs_pkg::FCS_CMD_BYTE, 1'b0);
        rd_stat(8'hD0);
        divider_ready <= 1'b1;
        apb(1'b1, STAT, 32'h0000_0010);
        // protected target and mass erase under protection, clear.
        launch(fcs_pkg::FCS_CMD_BYTE, 1'b1);
        rd_stat(8'hE0);
        apb(1'b1, STAT, 32'h0000_0000);
        rd_stat(8'hE0);
        apb(1'b1, STAT, 32'h0000_0020);
        protect_any <= 1'b1;
        launch(fcs_pkg::FCS_CMD_MASS, 1'b0);
        rd_stat(8'hE0);
        protect_any <= 1'b0;
        apb(1'b1, STAT, 32'h0000_0020);
        chk(8'(start_cnt), 8'h08);
        // stop entry while a command runs.
        launch(fcs_pkg::FCS_CMD_BYTE, 1'b0);
        @(posedge pclk);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        rd_stat(8'h90);
        finish_cmd(1'b0);
        rd_stat(8'hD0);
        chk(8'(start_cnt), 8'h09);
        complete_run();
    end

endmodule : fcs_ctrl_test
